// file: pkg/gstc_pkg.sv
`default_nettype none
package gstc_pkg;

    // Bus and counter widths
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned COUNT_W = 16;
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned IRQ_W   = 1;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CONTROL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_GATE     = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_COUNT_LO = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_COUNT_HI = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CLEAR    = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_ENABLE   = 8'h18;

    // Field positions
    localparam int unsigned BIT_ON       = 0;
    localparam int unsigned BIT_SYNC_DIS = 2;
    localparam int unsigned BIT_XTAL_EN  = 3;
    localparam int unsigned PS_LSB       = 4;
    localparam int unsigned SRC_LSB      = 6;
    localparam int unsigned BIT_GATE_EN  = 7;
    localparam int unsigned BIT_OVF      = 0;
    localparam int unsigned HTRANS_BUSY_BIT = 1;

    // Constants of the counting path and the bus response
    localparam logic [1:0]         PHASE_LAST = 2'h3;
    localparam logic [COUNT_W-1:0] COUNT_MAX  = 16'hffff;
    localparam logic [COUNT_W-1:0] COUNT_RST  = 16'h0000;
    localparam logic               HRESP_OKAY = 1'b0;

    // Count source encodings
    typedef enum logic [1:0] {
        GSTC_SRC_INSTR = 2'b00,
        GSTC_SRC_SYS   = 2'b01,
        GSTC_SRC_EXT   = 2'b10,
        GSTC_SRC_CAP   = 2'b11
    } gstc_src_t;

    // Counter control fields
    typedef struct packed {
        gstc_src_t  count_source_select;
        logic [1:0] prescale_select;
        logic       crystal_osc_enable;
        logic       sync_disable;
        logic       counter_on;
    } gstc_ctrl_t;

    localparam gstc_ctrl_t CTRL_RST = '{GSTC_SRC_INSTR, 2'h0, 1'b0,
                                        1'b0, 1'b0};

    // Word image of the control fields
    function automatic logic [DATA_W-1:0] gstc_pack_ctrl(gstc_ctrl_t c);
        logic [DATA_W-1:0] w;
        w = '0;
        w[BIT_ON]         = c.counter_on;
        w[BIT_SYNC_DIS]   = c.sync_disable;
        w[BIT_XTAL_EN]    = c.crystal_osc_enable;
        w[PS_LSB +: 2]    = c.prescale_select;
        w[SRC_LSB +: 2]   = c.count_source_select;
        return w;
    endfunction

    // Control fields from a written word
    function automatic gstc_ctrl_t gstc_unpack_ctrl(logic [DATA_W-1:0] w);
        gstc_ctrl_t c;
        c.counter_on          = w[BIT_ON];
        c.sync_disable        = w[BIT_SYNC_DIS];
        c.crystal_osc_enable  = w[BIT_XTAL_EN];
        c.prescale_select     = w[PS_LSB +: 2];
        c.count_source_select = gstc_src_t'(w[SRC_LSB +: 2]);
        return c;
    endfunction

endpackage
`default_nettype wire

// file: rtl/gstc_core.sv
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module gstc_core
    import gstc_pkg::*;
(
    input  wire logic              i_clk,         // System clock 100 MHz
    input  wire logic              i_resetn,      // Async reset, low
    input  wire logic              i_hsel,        // AHB slave select
    input  wire logic [DATA_W-1:0] i_haddr,       // AHB address
    input  wire logic [1:0]        i_htrans,      // AHB transfer type
    input  wire logic              i_hwrite,      // AHB write
    input  wire logic [2:0]        i_hsize,       // AHB size, word only
    input  wire logic [DATA_W-1:0] i_hwdata,      // AHB write data
    input  wire logic              i_hready,      // AHB bus ready
    input  wire logic              i_ext_count_pin,       // Count pin
    input  wire logic              i_crystal_in_pin,      // Crystal input
    input  wire logic              i_cap_sense_osc_clock, // Cap-sense osc
    input  wire logic              i_gate_permit, // Gate logic level
    input  wire logic              i_sleep,       // Processor asleep
    output logic      [DATA_W-1:0] o_hrdata,      // AHB read data
    output logic                   o_hreadyout,   // AHB slave ready
    output logic                   o_hresp,       // AHB response
    output logic                   o_crystal_out_pin, // Amplifier out
    output logic                   o_irq          // Interrupt level
);

    // Bus slave state
    logic              wr_pend_q;
    logic              rd_pend_q;
    logic [ADDR_W-1:0] addr_q;
    logic              hready_q;
    logic [DATA_W-1:0] hrdata_q;
    logic              bus_acc;
    logic              wr_lo;
    logic              wr_hi;
    logic              byte_wr;

    // Software state
    gstc_ctrl_t         ctrl_q;
    logic               gate_qualify_enable_q;
    logic [COUNT_W-1:0] count_q;
    logic [IRQ_W-1:0]   stat_q;
    logic [IRQ_W-1:0]   stat_d;
    logic [IRQ_W-1:0]   en_q;
    logic [IRQ_W-1:0]   en_d;
    logic [IRQ_W-1:0]   clr_mask;
    logic               irq_q;

    // Counting path
    logic [2:0] pins_s;
    logic       ext_s;
    logic       xtal_s;
    logic       cap_s;
    logic [1:0] phase_q;
    logic       phase_tick;
    logic       ext_lvl;
    logic       aligned_lvl_q;
    logic       cnt_lvl;
    logic       cnt_prev_q;
    logic       rise;
    logic       arm_q;
    logic       on_prev_q;
    logic       ext_mode;
    logic       awake;
    logic       run;
    logic       raw_tick;
    logic       inc;
    logic       ovf_evt;
    logic       xtal_out_q;

    // Address phase accepted on a ready, active, selected cycle
    assign bus_acc = i_hsel & i_htrans[HTRANS_BUSY_BIT] & i_hready;
    assign wr_lo   = wr_pend_q & (addr_q == OFF_COUNT_LO);
    assign wr_hi   = wr_pend_q & (addr_q == OFF_COUNT_HI);
    assign byte_wr = wr_lo | wr_hi;

    // Address phase capture; reads take one wait state so that a
    // write finishing at the same edge is seen by the read
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= '0;
            hready_q  <= 1'b1;
        end else begin
            wr_pend_q <= bus_acc & i_hwrite;
            rd_pend_q <= bus_acc & ~i_hwrite;
            hready_q  <= ~(bus_acc & ~i_hwrite);
            if (bus_acc) begin
                addr_q <= i_haddr[ADDR_W-1:0];
            end
        end
    end

    // Read data mux; unmapped and write-only offsets read zero
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hrdata_q <= '0;
        end else if (rd_pend_q) begin
            case (addr_q)
                OFF_CONTROL:  hrdata_q <= gstc_pack_ctrl(ctrl_q);
                OFF_GATE:     hrdata_q <= DATA_W'({gate_qualify_enable_q,
                                                   7'h00});
                OFF_COUNT_LO: hrdata_q <= DATA_W'(count_q[BYTE_W-1:0]);
                OFF_COUNT_HI: hrdata_q <= DATA_W'(count_q[COUNT_W-1:BYTE_W]);
                OFF_STATUS:   hrdata_q <= DATA_W'(stat_q);
                OFF_ENABLE:   hrdata_q <= DATA_W'(en_q);
                default:      hrdata_q <= '0;
            endcase
        end
    end

    // Control and gate registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q                <= CTRL_RST;
            gate_qualify_enable_q <= 1'b0;
        end else if (wr_pend_q) begin
            if (addr_q == OFF_CONTROL) begin
                ctrl_q <= gstc_unpack_ctrl(i_hwdata);
            end
            if (addr_q == OFF_GATE) begin
                gate_qualify_enable_q <= i_hwdata[BIT_GATE_EN];
            end
        end
    end

    // Pin levels enter the clock domain through two flops
    gstc_sync #(
        .WIDTH (3)
    ) u_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  ({i_cap_sense_osc_clock, i_crystal_in_pin,
                    i_ext_count_pin}),
        .o_sync   (pins_s)
    );
    assign ext_s  = pins_s[0];
    assign xtal_s = pins_s[1];
    assign cap_s  = pins_s[2];

    // Instruction cycle is four system clocks
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
    assign phase_tick = (phase_q == PHASE_LAST);

    // External level: cap-sense, crystal or pin
    assign ext_lvl = (ctrl_q.count_source_select == GSTC_SRC_CAP) ? cap_s :
                     (ctrl_q.crystal_osc_enable ? xtal_s : ext_s);
    assign ext_mode = ctrl_q.count_source_select[1];

    // Aligned copy of the synchronised level
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aligned_lvl_q <= 1'b0;
        end else if (phase_tick) begin
            aligned_lvl_q <= ext_lvl;
        end
    end

    // Mode switch may lose or add an edge
    assign cnt_lvl = ctrl_q.sync_disable ? ext_lvl : aligned_lvl_q;

    // Rising-edge detection of the count input
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_prev_q <= 1'b0;
        end else begin
            cnt_prev_q <= cnt_lvl;
        end
    end
    assign rise = cnt_lvl & ~cnt_prev_q;

    // Arm only after a low level is seen; disarm on enable
    // byte write or while off
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            arm_q     <= 1'b0;
            on_prev_q <= 1'b0;
        end else begin
            on_prev_q <= ctrl_q.counter_on;
            if (byte_wr || !ctrl_q.counter_on ||
                (ctrl_q.counter_on && !on_prev_q)) begin
                arm_q <= 1'b0;
            end else if (!cnt_lvl) begin
                arm_q <= 1'b1;
            end
        end
    end

    // Source selection of the raw count tick
    // Instruction clock ticks once per cycle
    // System clock ticks four per cycle
    always_comb begin
        case (ctrl_q.count_source_select)
            GSTC_SRC_INSTR: raw_tick = phase_tick;
            GSTC_SRC_SYS:   raw_tick = 1'b1;
            GSTC_SRC_EXT,
            GSTC_SRC_CAP:   raw_tick = rise & arm_q;
            default:        raw_tick = 1'b0;
        endcase
    end

    // Only asynchronous external counting survives sleep
    assign awake = ~i_sleep | (ext_mode & ctrl_q.sync_disable);
    assign run = ctrl_q.counter_on & awake &
                 (~gate_qualify_enable_q | i_gate_permit);

    gstc_prescale #(
        .PS_W  (2),
        .CNT_W (3)
    ) u_prescale (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_clear  (byte_wr),
        .i_select (ctrl_q.prescale_select),
        .i_tick   (raw_tick & run),
        .o_tick   (inc)
    );

    // Byte writes replace a byte of the running count
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count_q <= COUNT_RST;
        end else if (byte_wr) begin
            if (wr_lo) begin
                count_q[BYTE_W-1:0] <= i_hwdata[BYTE_W-1:0];
            end
            if (wr_hi) begin
                count_q[COUNT_W-1:BYTE_W] <= i_hwdata[BYTE_W-1:0];
            end
        end else if (inc) begin
            count_q <= count_q + 16'h0001;
        end
    end

    assign ovf_evt  = inc & ~byte_wr & (count_q == COUNT_MAX);
    assign clr_mask = (wr_pend_q && addr_q == OFF_CLEAR) ?
                      i_hwdata[IRQ_W-1:0] : '0;
    assign en_d     = (wr_pend_q && addr_q == OFF_ENABLE) ?
                      i_hwdata[IRQ_W-1:0] : en_q;
    // Set wins over a clear in the same cycle
    assign stat_d   = (stat_q & ~clr_mask) |
                      (IRQ_W'(ovf_evt) << BIT_OVF);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stat_q <= '0;
            en_q   <= '0;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            en_q   <= en_d;
            irq_q  <= |(stat_d & en_d);
        end
    end

    // Amplifier drives the inverted crystal level, sleep does not stop it
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            xtal_out_q <= 1'b0;
        end else begin
            xtal_out_q <= ctrl_q.crystal_osc_enable & ~xtal_s;
        end
    end

    assign o_hrdata          = hrdata_q;
    assign o_hreadyout       = hready_q;
    assign o_hresp           = HRESP_OKAY;
    assign o_crystal_out_pin = xtal_out_q;
    assign o_irq             = irq_q;

    a_byte_load : assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_lo |=> count_q[BYTE_W-1:0] == $past(i_hwdata[BYTE_W-1:0]))
        else $error("low byte write not loaded");

    a_off_holds : assert property (@(posedge i_clk) disable iff (!i_resetn)
        !ctrl_q.counter_on && !byte_wr |=> $stable(count_q))
        else $error("count moved while off");

    a_gate_holds : assert property (@(posedge i_clk) disable iff (!i_resetn)
        gate_qualify_enable_q && !i_gate_permit |-> !inc)
        else $error("count advanced with gate closed");

    a_instr_rate : assert property (@(posedge i_clk) disable iff (!i_resetn)
        inc && ctrl_q.count_source_select == GSTC_SRC_INSTR
        |=> !inc ##1 !inc ##1 !inc)
        else $error("instruction clock counted too fast");

    a_sys_rate : assert property (@(posedge i_clk) disable iff (!i_resetn)
        run && ctrl_q.count_source_select == GSTC_SRC_SYS &&
        ctrl_q.prescale_select == 2'h0 && !byte_wr |-> inc)
        else $error("system clock missed a count");

    a_need_fall : assert property (@(posedge i_clk) disable iff (!i_resetn)
        byte_wr && ext_mode |=> !arm_q)
        else $error("armed without a falling edge");

    a_sleep_freeze : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        i_sleep && !(ext_mode && ctrl_q.sync_disable) |-> !inc)
        else $error("counted in sleep while synchronous");

    a_ovf_sticky : assert property (@(posedge i_clk) disable iff (!i_resetn)
        ovf_evt |=> stat_q[BIT_OVF] && count_q == COUNT_RST)
        else $error("rollover did not set overflow");

    a_irq_level : assert property (@(posedge i_clk) disable iff (!i_resetn)
        ovf_evt && en_q[BIT_OVF] && !(wr_pend_q && addr_q == OFF_ENABLE)
        |=> o_irq)
        else $error("enabled overflow did not raise interrupt");

    a_read_wait : assert property (@(posedge i_clk) disable iff (!i_resetn)
        bus_acc && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read did not take one wait state");

endmodule // gstc_core
`default_nettype wire

// file: rtl/gstc_prescale.sv
`timescale 1ns/10ps
`default_nettype none
module gstc_prescale #(
    parameter int unsigned PS_W  = 2,
    parameter int unsigned CNT_W = 3
) (
    input  wire logic            i_clk,    // System clock
    input  wire logic            i_resetn, // Async reset, low
    input  wire logic            i_clear,  // Restart division
    input  wire logic [PS_W-1:0] i_select, // Divide by 2**select
    input  wire logic            i_tick,   // Source edge
    output logic                 o_tick    // Divided edge
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] last;

    // Terminal count of the selected ratio; at or past it counts as
    // terminal, so a smaller ratio chosen mid-count takes effect at once
    assign last   = CNT_W'((1 << i_select) - 1);
    assign o_tick = i_tick & (cnt_q >= last) & ~i_clear;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= '0;
        end else if (i_clear) begin
            cnt_q <= '0;
        end else if (i_tick) begin
            cnt_q <= (cnt_q >= last) ? '0 : cnt_q + CNT_W'(1);
        end
    end

    a_clear_zero : assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_clear |=> cnt_q == '0)
        else $error("prescaler not cleared after byte write");

    a_ratio_one : assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_select == '0) && i_tick && !i_clear |-> o_tick)
        else $error("divide by one dropped an edge");

    a_no_free_tick : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        !i_tick |-> !o_tick)
        else $error("prescaler ticked without source edge");

endmodule // gstc_prescale
`default_nettype wire

// file: rtl/gstc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module gstc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_clk,    // System clock
    input  wire logic             i_resetn, // Async reset, low
    input  wire logic [WIDTH-1:0] i_async,  // Pin levels
    output logic      [WIDTH-1:0] o_sync    // Levels in clock domain
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Two flops; the first one is read only by the second
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule // gstc_sync
`default_nettype wire

// file: verif/gstc_core_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module gstc_core_tb_top
    import gstc_pkg::*;
;

    logic              clk;
    logic              resetn;
    logic              hsel;
    logic [DATA_W-1:0] haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [DATA_W-1:0] hwdata;
    logic [DATA_W-1:0] hrdata;
    logic              hready;
    logic              hresp;
    logic              permit;
    logic              sleep;
    logic              ext_pin;
    logic              crystal;
    logic              cap;
    logic              xtal_out;
    logic              irq;
    int                n_errors;
    int                tests_run;
    logic [7:0]        rc [6] = '{8'h01, 8'h41, 8'h71, 8'h11, 8'h61, 8'h31};
    int                re [6] = '{100, 400, 50, 50, 100, 12};

    gstc_core i_gstc_core (
        .i_clk(clk), .i_resetn(resetn), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .i_ext_count_pin(ext_pin),
        .i_crystal_in_pin(crystal), .i_cap_sense_osc_clock(cap),
        .i_gate_permit(permit), .i_sleep(sleep), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp),
        .o_crystal_out_pin(xtal_out), .o_irq(irq)
    );
    gstc_pin_model i_gstc_pin_model (
        .i_clk(clk), .o_ext_pin(ext_pin), .o_crystal(crystal), .o_cap(cap)
    );

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic wrap_up();
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [DATA_W-1:0] e,
                       input logic [DATA_W-1:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask

    // Rates are judged within a few counts: bus turnaround blurs edges
    task automatic near(input string s, input int e,
                        input logic [COUNT_W-1:0] g);
        tests_run++;
        if ((^g === 1'bx) || int'(g) < e - 4 || int'(g) > e + 4) begin
            n_errors++;
            $display("[FAIL] %s expected %0d seen %0d", s, e, g);
        end
    endtask

    // Single AHB-Lite word transfer; waits are bounded, not open-ended
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= DATA_W'(a);
        // Address phase stands until hready is seen high at an edge
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        htrans <= 2'h0;
        hwdata <= d;
        // Data phase stands until the slave is ready again
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        r = hrdata;
        chk("hresp", '0, DATA_W'(hresp));
        if (n >= 64) begin
            n_errors++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] r;
        bus(1'b0, a, '0, r);
        chk("register", e, r);
    endtask

    task automatic rd_cnt(output logic [COUNT_W-1:0] c);
        logic [DATA_W-1:0] lo;
        logic [DATA_W-1:0] hi;
        bus(1'b0, OFF_COUNT_LO, '0, lo);
        bus(1'b0, OFF_COUNT_HI, '0, hi);
        c = {hi[BYTE_W-1:0], lo[BYTE_W-1:0]};
    endtask

    task automatic set_cnt(input logic [COUNT_W-1:0] v);
        wr(OFF_COUNT_LO, DATA_W'(v[7:0]));
        wr(OFF_COUNT_HI, DATA_W'(v[15:8]));
    endtask

    task automatic cnt_is(input logic [COUNT_W-1:0] e);
        logic [COUNT_W-1:0] c;
        rd_cnt(c);
        chk("count", DATA_W'(e), DATA_W'(c));
    endtask

    task automatic feed(input int sel, input int n);
        i_gstc_pin_model.pulses(sel, n, 8);
        repeat (16) @(posedge clk);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    // Offsets 0x00 to 0x1c, mapped or not, read zero after reset
    task automatic t_reset();
        for (int k = 0; k < 8; k++) rdc(ADDR_W'(4 * k), '0);
        chk("irq", 1'b0, irq);
    endtask

    // Byte writes replace one byte, data sits in the low bits
    task automatic t_bytes();
        set_cnt(16'h1234);
        cnt_is(16'h1234);
        wr(OFF_COUNT_HI, 32'h000001ab);
        cnt_is(16'hab34);
    endtask

    // Source and prescale table, then the count holds once off
    task automatic t_rate();
        logic [COUNT_W-1:0] c;
        logic [COUNT_W-1:0] c2;
        for (int k = 0; k < 6; k++) begin
            set_cnt(16'h0000);
            wr(OFF_CONTROL, DATA_W'(rc[k]));
            repeat (400) @(posedge clk);
            wr(OFF_CONTROL, 32'h00000000);
            rd_cnt(c);
            near("rate", re[k], c);
            repeat (20) @(posedge clk);
            rd_cnt(c2);
            chk("held", DATA_W'(c), DATA_W'(c2));
        end
    endtask

    // Gate qualifying: closed gate holds, open gate counts
    task automatic t_gate();
        logic [COUNT_W-1:0] c;
        wr(OFF_GATE, 32'h00000080);
        permit <= 1'b0;
        set_cnt(16'h0000);
        wr(OFF_CONTROL, 32'h00000041);
        repeat (200) @(posedge clk);
        cnt_is(16'h0000);
        permit <= 1'b1;
        set_cnt(16'h0000);
        repeat (200) @(posedge clk);
        wr(OFF_CONTROL, 32'h00000000);
        rd_cnt(c);
        near("gated", 202, c);
        wr(OFF_GATE, 32'h00000000);
    endtask

    // Pin, crystal and cap-sense sources, and prescaler clearing
    task automatic t_ext();
        wr(OFF_CONTROL, 32'h00000081);
        set_cnt(16'h0000);
        feed(0, 5);
        cnt_is(16'h0005);
        wr(OFF_CONTROL, 32'h00000088);
        repeat (50) @(posedge clk);
        wr(OFF_CONTROL, 32'h00000089);
        settle();
        chk("xtal_out", 1'b1, xtal_out);
        set_cnt(16'h0000);
        feed(0, 3);
        feed(1, 4);
        cnt_is(16'h0004);
        wr(OFF_CONTROL, 32'h000000c1);
        set_cnt(16'h0000);
        feed(2, 6);
        cnt_is(16'h0006);
        wr(OFF_CONTROL, 32'h00000091);
        set_cnt(16'h0000);
        feed(0, 1);
        set_cnt(16'h0000);
        feed(0, 1);
        cnt_is(16'h0000);
        feed(0, 1);
        cnt_is(16'h0001);
        wr(OFF_CONTROL, 32'h00000000);
        settle();
        chk("xtal_out", 1'b0, xtal_out);
    endtask

    // Sleep: only async external counts; overflow, mask and clear
    task automatic t_sleep();
        wr(OFF_CONTROL, 32'h00000081);
        sleep <= 1'b1;
        set_cnt(16'h0000);
        feed(0, 3);
        cnt_is(16'h0000);
        wr(OFF_CONTROL, 32'h00000085);
        feed(0, 3);
        cnt_is(16'h0003);
        set_cnt(16'hffff);
        wr(OFF_ENABLE, 32'h00000001);
        feed(0, 1);
        cnt_is(16'h0000);
        rdc(OFF_STATUS, 32'h00000001);
        chk("irq", 1'b1, irq);
        wr(OFF_STATUS, 32'h00000000);
        rdc(OFF_STATUS, 32'h00000001);
        wr(OFF_ENABLE, 32'h00000000);
        settle();
        chk("irq", 1'b0, irq);
        wr(OFF_ENABLE, 32'h00000001);
        settle();
        chk("irq", 1'b1, irq);
        wr(OFF_CLEAR, 32'h00000001);
        settle();
        chk("irq", 1'b0, irq);
        rdc(OFF_STATUS, 32'h00000000);
        sleep <= 1'b0;
    endtask

    // Main sequence
    initial begin
        resetn    = 1'b0;
        hsel      = 1'b0;
        haddr     = '0;
        htrans    = 2'h0;
        hwrite    = 1'b0;
        hsize     = 3'h2;
        hwdata    = '0;
        permit    = 1'b1;
        sleep     = 1'b0;
        n_errors  = 0;
        tests_run = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_bytes();
        t_rate();
        t_gate();
        t_ext();
        t_sleep();
        wrap_up();
    end
endmodule // gstc_core_tb_top
`default_nettype wire

// file: verif/gstc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module gstc_pin_model (
    input  wire logic i_clk,     // System clock, paces edges
    output logic      o_ext_pin, // External count pin
    output logic      o_crystal, // Crystal oscillator level
    output logic      o_cap      // Cap-sense oscillator level
);
    // Sources stand still and low between bursts, so no stray edge
    initial begin
        o_ext_pin = 1'b0;
        o_crystal = 1'b0;
        o_cap     = 1'b0;
    end

    // Drive one of the three count sources
    task automatic drive(input int sel, input logic v);
        case (sel)
            0: o_ext_pin <= v;
            1: o_crystal <= v;
            default: o_cap <= v;
        endcase
    endtask

    // low before rise
    // Each pulse is low for half, high for half, then low again
    task automatic pulses(input int sel, input int n, input int half);
        for (int k = 0; k < n; k++) begin
            repeat (half) @(posedge i_clk);
            drive(sel, 1'b1);
            repeat (half) @(posedge i_clk);
            drive(sel, 1'b0);
        end
    endtask
endmodule // gstc_pin_model
`default_nettype wire
